/* File: hdl/system_address_decoder.sv */
// system address decoder: sorts core accesses into regions, picks the bus,
// performs bit-band alias read and read-modify-write, and paces external memory
// assumes one request at a time from the core and single-cycle internal targets
`timescale 1ns/1ps
//
// Behaviour
// - lowest half gigabyte is program code; vectors sit at address zero
// - sram region holds 1 MB bit-band area aliased by 32 MB at 0x22000000; here only alias words for the 32K block to 0x20007FFF decode, the rest error
// - alias word write updates one sram bit from written bit 0, atomically
// - alias word read returns only the addressed sram bit, zero or one
// - external memory control registers decode at 0x40005400 to 0x400054FF
// - external memory starts at 0x60000000 with at most 24 address bits
// - external data path is 8 or 16 bits wide
// - instruction fetch from external memory only when it is 16 bits wide
// - each external memory access occupies four bus clock cycles
// - synchronous or asynchronous external memory, only one type at a time
// - external memory has no access protection or code security
// - instruction and data code buses carry only program code addresses
// - system bus carries 0x20000000-0xDFFFFFFF and 0xE0100000-0xFFFFFFFF
// - system bus also takes fetches in 0x20000000-0x3FFFFFFF, possibly slower
// - private peripheral bus serves 0xE0000000-0xE00FFFFF for control and debug
// - unaligned word and half-word accesses complete, with extra cycles; the decoder adds one cycle, none for external memory
// - 32K sram block decoded at 0x1FFF8000, top of code region
// - 32K sram block decoded at base of sram region, ending at 0x20007FFF
module system_address_decoder
    import addr_decode_pkg::*;
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // core request
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic req_fetch,
    input wire logic [1:0] req_size,
    input wire logic [31:0] req_addr,
    input wire logic [31:0] req_wdata,
    // external memory configuration straps
    input wire logic ext_width16,
    input wire logic ext_sync_mode,
    // target read data
    input wire logic [31:0] code_rdata,
    input wire logic [31:0] sram_rdata,
    input wire logic [31:0] periph_rdata,
    input wire logic [15:0] ext_rdata,
    input wire logic [31:0] ppb_rdata,
    input wire logic [31:0] sys_rdata,
    // core response
    output logic resp_valid,
    output logic resp_error,
    output logic [31:0] resp_rdata,
    // routing
    output target_t target_r,
    output bus_sel_t bus_sel_r,
    output logic emi_ctrl_sel_r,
    output logic vector_fetch_r,
    // sram port
    output logic sram_en_r,
    output logic sram_we_r,
    output logic [31:0] sram_addr_r,
    output logic [31:0] sram_wdata_r,
    // external memory port
    output logic ext_en_r,
    output logic ext_we_r,
    output logic ext_sync_r,
    output logic [23:0] ext_addr_r,
    output logic [15:0] ext_wdata_r
);

    ////////////////////////////////////////////////////////////////////////
    // decode

    wire logic in_code = req_addr <= CODE_LAST;
    wire logic in_flash = req_addr <= FLASH_LAST;
    wire logic in_sram_lo = req_addr >= SRAM_LO_BASE && in_code;
    wire logic in_sram_hi = req_addr >= SRAM_HI_BASE && req_addr <= SRAM_HI_LAST;
    wire logic in_alias = req_addr >= ALIAS_BASE && req_addr <= ALIAS_LAST;
    wire logic in_sram_region = req_addr >= SRAM_HI_BASE && req_addr <= SRAM_REGION_LAST;
    wire logic in_periph = req_addr >= PERIPH_BASE && req_addr <= PERIPH_LAST;
    wire logic in_emi_ctrl = req_addr >= EMI_CTRL_BASE && req_addr <= EMI_CTRL_LAST;
    wire logic in_ext = req_addr >= EXT_BASE && req_addr <= EXT_LAST;
    // external ram space beyond the 24 address bits is a hole, not system bus
    wire logic in_sys = in_sram_region || (req_addr > EXT_SPACE_LAST && req_addr <= SYS_LAST)
        || req_addr >= SYS_HI_BASE;
    wire logic in_ppb = req_addr >= PPB_BASE && req_addr <= PPB_LAST;
    // only a 16-bit external memory may hold code; no security check exists there
    wire logic ext_fetch_bad = in_ext && req_fetch && !ext_width16;
    // fetches above the sram region have no path, except into external memory
    wire logic fetch_bad = req_fetch && !in_code && !(in_sram_region) && !ext_fetch_bad
        && !in_ext;
    wire logic alias_hit = in_alias;
    // alias word n maps to sram bit n: byte = base + n/8, word bit = n mod 32
    wire logic [31:0] alias_word_addr = SRAM_HI_BASE + {12'h000, req_addr[24:7], 2'b00};
    wire logic [4:0] alias_bit = req_addr[6:2];
    wire logic alias_mapped = alias_word_addr <= SRAM_HI_LAST;

    target_t tgt_dec;
    always_comb begin
        // priority chain gives exactly one target
        tgt_dec = TGT_NONE;
        if (in_flash || in_sram_lo) begin
            tgt_dec = TGT_CODE;
        end else if (in_sram_hi || (alias_hit && alias_mapped)) begin
            tgt_dec = TGT_SRAM;
        end else if (in_emi_ctrl || in_periph) begin
            tgt_dec = TGT_PERIPH;
        end else if (in_ext) begin
            tgt_dec = TGT_EXT;
        end else if (in_ppb) begin
            tgt_dec = TGT_PPB;
        end else if (in_sys && !in_sram_region) begin
            tgt_dec = TGT_SYS;
        end
    end

    wire logic dec_error = tgt_dec == TGT_NONE || fetch_bad || ext_fetch_bad;
    wire bus_sel_t bus_dec = in_code ? (req_fetch ? BUS_INSTRUCTION_CODE_BUS : BUS_DATA_CODE_BUS)
        : in_ppb ? BUS_PRIV : BUS_SYSTEM;
    wire logic unaligned = (req_size == 2'b10 && req_addr[1:0] != 2'b00)
        || (req_size == 2'b01 && req_addr[0]);

    ////////////////////////////////////////////////////////////////////////
    // read data selection

    logic [31:0] sram_word_r;
    logic [4:0] bit_r;
    logic alias_r;
    logic [31:0] rdata_mux;
    always_comb begin
        case (target_r)
            TGT_CODE: rdata_mux = code_rdata;
            TGT_SRAM: rdata_mux = alias_r ? {31'h0000_0000, sram_rdata[bit_r]} : sram_rdata;
            TGT_PERIPH: rdata_mux = periph_rdata;
            TGT_EXT: rdata_mux = ext_width16 ? {16'h0000, ext_rdata} : {24'h00_0000, ext_rdata[7:0]};
            TGT_PPB: rdata_mux = ppb_rdata;
            TGT_SYS: rdata_mux = sys_rdata;
            default: rdata_mux = 32'h0000_0000;
        endcase
    end
    // bit-band merge for the write phase
    wire logic [31:0] merged = (sram_rdata & ~(32'h0000_0001 << bit_r))
        | ({31'h0000_0000, sram_word_r[0]} << bit_r);

    ////////////////////////////////////////////////////////////////////////
    // sequencer

    state_t state_r, state_nxt;
    logic [2:0] cnt_r;
    logic write_r;
    wire logic accept = state_r == ST_IDLE && req_valid;
    // external accesses stretch to four cycles; unaligned adds one
    wire logic [2:0] wait_init = (tgt_dec == TGT_EXT) ? EXT_CNT_INIT
        : unaligned ? 3'(UNALIGNED_EXTRA) : 3'h0;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (accept && !dec_error) begin
                    state_nxt = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (cnt_r == 3'h0) begin
                    state_nxt = (alias_r && write_r) ? ST_RMW : ST_IDLE;
                end
            end
            ST_RMW: state_nxt = ST_IDLE;
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_r <= ST_IDLE;
            cnt_r <= 3'h0;
            write_r <= 1'b0;
            alias_r <= 1'b0;
            bit_r <= 5'h00;
            sram_word_r <= 32'h0000_0000;
        end else begin
            state_r <= state_nxt;
            if (accept) begin
                cnt_r <= wait_init;
                write_r <= req_write;
                alias_r <= alias_hit;
                bit_r <= alias_bit;
                sram_word_r <= req_wdata;
            end else if (cnt_r != 3'h0) begin
                cnt_r <= cnt_r - 3'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    wire logic done = (state_r == ST_WAIT && cnt_r == 3'h0 && !(alias_r && write_r))
        || state_r == ST_RMW;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            resp_valid <= 1'b0;
            resp_error <= 1'b0;
            resp_rdata <= 32'h0000_0000;
            target_r <= TGT_NONE;
            bus_sel_r <= BUS_INSTRUCTION_CODE_BUS;
            emi_ctrl_sel_r <= 1'b0;
            vector_fetch_r <= 1'b0;
            sram_en_r <= 1'b0;
            sram_we_r <= 1'b0;
            sram_addr_r <= 32'h0000_0000;
            sram_wdata_r <= 32'h0000_0000;
            ext_en_r <= 1'b0;
            ext_we_r <= 1'b0;
            ext_sync_r <= 1'b0;
            ext_addr_r <= 24'h00_0000;
            ext_wdata_r <= 16'h0000;
        end else begin
            resp_valid <= (accept && dec_error) || done;
            resp_error <= accept && dec_error;
            resp_rdata <= done ? rdata_mux : 32'h0000_0000;
            ext_sync_r <= ext_sync_mode;
            if (accept) begin
                target_r <= dec_error ? TGT_NONE : tgt_dec;
                bus_sel_r <= bus_dec;
                emi_ctrl_sel_r <= in_emi_ctrl;
                vector_fetch_r <= req_fetch && req_addr == VECTOR_BASE;
                sram_en_r <= !dec_error && tgt_dec == TGT_SRAM;
                // alias writes read first, then write the merged word
                sram_we_r <= !dec_error && tgt_dec == TGT_SRAM && req_write && !alias_hit;
                sram_addr_r <= alias_hit ? alias_word_addr : req_addr;
                sram_wdata_r <= req_wdata;
                ext_en_r <= !dec_error && tgt_dec == TGT_EXT;
                ext_we_r <= req_write;
                ext_addr_r <= req_addr[EXT_ADDR_W-1:0];
                ext_wdata_r <= ext_width16 ? req_wdata[15:0] : {8'h00, req_wdata[7:0]};
            end else if (state_nxt == ST_RMW) begin
                sram_we_r <= 1'b1;
                sram_wdata_r <= merged;
            end else if (state_nxt == ST_IDLE) begin
                sram_en_r <= 1'b0;
                sram_we_r <= 1'b0;
                ext_en_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    property p_ext_four;
        @(posedge ref_clk) disable iff (srst)
        $rose(ext_en_r) |-> ext_en_r [*4] ##1 !ext_en_r;
    endproperty
    a_ext_four: assert property (p_ext_four) else $error("ext access not four cycles");

    property p_error_unmapped;
        @(posedge ref_clk) disable iff (srst)
        (accept && tgt_dec == TGT_NONE) |=> (resp_valid && resp_error);
    endproperty
    a_error_unmapped: assert property (p_error_unmapped) else $error("no error on hole");

    property p_alias_read;
        @(posedge ref_clk) disable iff (srst)
        (resp_valid && !resp_error && target_r == TGT_SRAM && alias_r)
            |-> resp_rdata[31:1] == 31'h0000_0000;
    endproperty
    a_alias_read: assert property (p_alias_read) else $error("alias read not 0 or 1");

    sequence s_alias_wr;
        accept && alias_hit && req_write && !dec_error;
    endsequence
    property p_alias_rmw;
        @(posedge ref_clk) disable iff (srst)
        s_alias_wr |=> !sram_we_r ##1 sram_we_r;
    endproperty
    a_alias_rmw: assert property (p_alias_rmw) else $error("alias write not merged");

    property p_code_bus;
        @(posedge ref_clk) disable iff (srst)
        (accept && !in_code) |=> bus_sel_r != BUS_INSTRUCTION_CODE_BUS && bus_sel_r != BUS_DATA_CODE_BUS;
    endproperty
    a_code_bus: assert property (p_code_bus) else $error("code bus outside code");

    property p_ext_fetch;
        @(posedge ref_clk) disable iff (srst)
        (accept && in_ext && req_fetch && !ext_width16) |=> resp_error && !ext_en_r;
    endproperty
    a_ext_fetch: assert property (p_ext_fetch) else $error("8-bit ext fetch allowed");

    property p_ppb_bus;
        @(posedge ref_clk) disable iff (srst)
        (accept && in_ppb) |=> bus_sel_r == BUS_PRIV;
    endproperty
    a_ppb_bus: assert property (p_ppb_bus) else $error("ppb not routed");

    property p_sys_fetch;
        @(posedge ref_clk) disable iff (srst)
        (accept && req_fetch && in_sram_hi) |=> bus_sel_r == BUS_SYSTEM && !resp_error;
    endproperty
    a_sys_fetch: assert property (p_sys_fetch) else $error("sram fetch refused");

    property p_ext_addr;
        @(posedge ref_clk) disable iff (srst)
        (accept && !dec_error && tgt_dec == TGT_EXT)
            |=> ext_en_r && ext_addr_r == $past(req_addr[EXT_ADDR_W-1:0]);
    endproperty
    a_ext_addr: assert property (p_ext_addr) else $error("ext address not low bits");

    property p_ext_wnarrow;
        @(posedge ref_clk) disable iff (srst)
        (accept && tgt_dec == TGT_EXT && !ext_width16) |=> ext_wdata_r[15:8] == 8'h00;
    endproperty
    a_ext_wnarrow: assert property (p_ext_wnarrow) else $error("8-bit ext write wide");

    property p_ext_rnarrow;
        @(posedge ref_clk) disable iff (srst)
        (resp_valid && !resp_error && target_r == TGT_EXT && !$past(ext_width16))
            |-> resp_rdata[31:8] == 24'h00_0000;
    endproperty
    a_ext_rnarrow: assert property (p_ext_rnarrow) else $error("8-bit ext read wide");

    property p_sync_follow;
        @(posedge ref_clk) disable iff (srst)
        !$past(srst) |-> ext_sync_r == $past(ext_sync_mode);
    endproperty
    a_sync_follow: assert property (p_sync_follow) else $error("memory type strap lost");

    property p_vector;
        @(posedge ref_clk) disable iff (srst)
        (accept && req_fetch && req_addr == VECTOR_BASE)
            |=> vector_fetch_r && bus_sel_r == BUS_INSTRUCTION_CODE_BUS;
    endproperty
    a_vector: assert property (p_vector) else $error("vector fetch not flagged");

    property p_unaligned;
        @(posedge ref_clk) disable iff (srst)
        (accept && unaligned && !dec_error && tgt_dec != TGT_EXT && !alias_hit)
            |=> !resp_valid ##1 !resp_valid ##1 resp_valid;
    endproperty
    a_unaligned: assert property (p_unaligned) else $error("unaligned timing wrong");

endmodule : system_address_decoder

/* File: pkg/addr_decode_pkg.sv */
// address map constants, target codes and timing for the system address decoder
// assumes a 32-bit byte address from the core and a 20 MHz bus clock
package addr_decode_pkg;
    localparam int ADDR_W = 32;
    // program code window
    localparam logic [31:0] CODE_BASE = 32'h0000_0000;
    localparam logic [31:0] CODE_LAST = 32'h1FFF_FFFF;
    localparam logic [31:0] VECTOR_BASE = 32'h0000_0000;
    localparam logic [31:0] FLASH_LAST = 32'h0003_FFFF;
    localparam logic [31:0] SRAM_LO_BASE = 32'h1FFF_8000;
    localparam logic [31:0] SRAM_HI_BASE = 32'h2000_0000;
    localparam logic [31:0] SRAM_HI_LAST = 32'h2000_7FFF;
    // sram region and bit-band
    localparam logic [31:0] SRAM_REGION_LAST = 32'h3FFF_FFFF;
    localparam logic [31:0] BITBAND_LAST = 32'h200F_FFFF;
    localparam logic [31:0] ALIAS_BASE = 32'h2200_0000;
    localparam logic [31:0] ALIAS_LAST = 32'h23FF_FFFF;
    // peripherals
    localparam logic [31:0] PERIPH_BASE = 32'h4000_0000;
    localparam logic [31:0] PERIPH_LAST = 32'h5FFF_FFFF;
    localparam logic [31:0] EMI_CTRL_BASE = 32'h4000_5400;
    localparam logic [31:0] EMI_CTRL_LAST = 32'h4000_54FF;
    // external memory
    localparam logic [31:0] EXT_BASE = 32'h6000_0000;
    localparam int EXT_ADDR_W = 24;
    localparam logic [31:0] EXT_LAST = 32'h60FF_FFFF;
    localparam logic [31:0] EXT_SPACE_LAST = 32'h9FFF_FFFF;
    localparam logic [31:0] SYS_LAST = 32'hDFFF_FFFF;
    // private peripheral bus
    localparam logic [31:0] PPB_BASE = 32'hE000_0000;
    localparam logic [31:0] PPB_LAST = 32'hE00F_FFFF;
    localparam logic [31:0] SYS_HI_BASE = 32'hE010_0000;
    // external access timing: four bus cycles at 20 MHz
    localparam int EXT_ACCESS_CYCLES = 4;
    localparam int CLK_PERIOD_NS = 50;
    localparam int UNALIGNED_EXTRA = 1;
    localparam logic [2:0] EXT_CNT_INIT = 3'(EXT_ACCESS_CYCLES - 1);

    typedef enum logic [2:0] {
        TGT_NONE = 3'b000,
        TGT_CODE = 3'b001,
        TGT_SRAM = 3'b010,
        TGT_PERIPH = 3'b011,
        TGT_EXT = 3'b100,
        TGT_PPB = 3'b101,
        TGT_SYS = 3'b110
    } target_t;

    typedef enum logic [1:0] {
        BUS_INSTRUCTION_CODE_BUS = 2'b00,
        BUS_DATA_CODE_BUS = 2'b01,
        BUS_SYSTEM = 2'b10,
        BUS_PRIV = 2'b11
    } bus_sel_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_RMW = 2'b10
    } state_t;
endpackage : addr_decode_pkg

/* File: testbench/target_model.sv */
// far-side targets: small sram array, external memory, fixed-data buses
// assumes the decoder drives registered enables and addresses on ref_clk
`timescale 1ns/1ps
module target_model
    import addr_decode_pkg::*;
#(
    parameter logic [31:0] CODE_PAT = 32'h0,
    parameter logic [31:0] PERIPH_PAT = 32'h0,
    parameter logic [31:0] PPB_PAT = 32'h0,
    parameter logic [31:0] SYS_PAT = 32'h0
)
(
    // clock
    input wire logic ref_clk,
    // sram port
    input wire logic sram_en_r,
    input wire logic sram_we_r,
    input wire logic [31:0] sram_addr_r,
    input wire logic [31:0] sram_wdata_r,
    // external memory port
    input wire logic ext_en_r,
    input wire logic [23:0] ext_addr_r,
    // read data
    output logic [31:0] sram_rdata,
    output logic [15:0] ext_rdata,
    output logic [31:0] code_rdata,
    output logic [31:0] periph_rdata,
    output logic [31:0] ppb_rdata,
    output logic [31:0] sys_rdata
);
    logic [31:0] mem [16];
    logic [31:0] churn_r;
    initial begin
        churn_r = 32'h0;
        for (int i = 0; i < 16; i++) mem[i] = 32'h0;
    end
    // deselected sram and external data lines change every cycle so a stale value never matches
    always @(posedge ref_clk) begin
        churn_r <= churn_r + 32'h9E37_79B9;
        if (sram_en_r && sram_we_r) mem[sram_addr_r[5:2]] <= sram_wdata_r;
    end
    assign sram_rdata = sram_en_r ? mem[sram_addr_r[5:2]] : churn_r;
    assign ext_rdata = ext_en_r ? (ext_addr_r[15:0] ^ 16'h5A3C) : churn_r[15:0];
    assign code_rdata = CODE_PAT;
    assign periph_rdata = PERIPH_PAT;
    assign ppb_rdata = PPB_PAT;
    assign sys_rdata = SYS_PAT;
endmodule : target_model

/* File: testbench/system_address_decoder_tb.sv */
// self-checking bench: corner and random accesses through the decoder
// assumes target_model on the far side, one request outstanding
`timescale 1ns/1ps
module system_address_decoder_tb;
    import addr_decode_pkg::*;
    localparam logic [31:0] CODE_PAT = 32'h1357_9BDF;
    localparam logic [31:0] PERIPH_PAT = 32'h2468_ACE0;
    localparam logic [31:0] PPB_PAT = 32'hC0DE_0F0F;
    localparam logic [31:0] SYS_PAT = 32'h5A5A_3C3C;
    logic ref_clk, srst, req_valid, req_write, req_fetch, ext_width16, ext_sync_mode;
    logic [1:0] req_size;
    logic [31:0] req_addr, req_wdata, code_rdata, sram_rdata, periph_rdata, ppb_rdata;
    logic [31:0] sys_rdata, resp_rdata, sram_addr_r, sram_wdata_r, rd, wv;
    logic [15:0] ext_rdata, ext_wdata_r, xw;
    logic [23:0] ext_addr_r, xa;
    logic resp_valid, resp_error, emi_ctrl_sel_r, vector_fetch_r, sram_en_r, sram_we_r;
    logic ext_en_r, ext_we_r, ext_sync_r, er, v;
    target_t target_r;
    bus_sel_t bus_sel_r;
    int bad_count, tests_run, lat, ext_cyc, b, k;
    int seed = 58634;
    logic [31:0] bases [9] = '{CODE_BASE, SRAM_LO_BASE, SRAM_HI_BASE, ALIAS_BASE, PERIPH_BASE,
        EXT_BASE, PPB_BASE, 32'hA000_0000, SYS_HI_BASE};
    // bit 32 marks an instruction fetch
    logic [32:0] corners [$] = '{{1'h1, VECTOR_BASE}, {1'h0, FLASH_LAST - 32'h3},
        {1'h0, 32'h0004_0000}, {1'h1, SRAM_LO_BASE}, {1'h0, CODE_LAST - 32'h3},
        {1'h0, SRAM_HI_BASE}, {1'h1, SRAM_HI_LAST - 32'h3}, {1'h0, SRAM_HI_LAST + 32'h1},
        {1'h0, ALIAS_BASE}, {1'h0, 32'h220F_FFFC}, {1'h0, 32'h2210_0000},
        {1'h0, EMI_CTRL_BASE}, {1'h0, EMI_CTRL_LAST - 32'h3}, {1'h0, EMI_CTRL_BASE - 32'h4},
        {1'h1, PERIPH_BASE}, {1'h0, EXT_BASE}, {1'h0, PPB_BASE}, {1'h0, PPB_LAST - 32'h3},
        {1'h1, PPB_BASE}, {1'h0, SYS_HI_BASE}, {1'h1, SYS_HI_BASE}, {1'h0, 32'hA000_0000},
        {1'h0, SYS_LAST - 32'h3}, {1'h0, 32'hFFFF_FFFC}, {1'h0, EXT_LAST + 32'h1},
        {1'h0, 32'h9FFF_FFFC}};

    system_address_decoder dut (.ref_clk, .srst, .req_valid, .req_write, .req_fetch,
        .req_size, .req_addr, .req_wdata, .ext_width16, .ext_sync_mode, .code_rdata,
        .sram_rdata, .periph_rdata, .ext_rdata, .ppb_rdata, .sys_rdata, .resp_valid,
        .resp_error, .resp_rdata, .target_r, .bus_sel_r, .emi_ctrl_sel_r, .vector_fetch_r,
        .sram_en_r, .sram_we_r, .sram_addr_r, .sram_wdata_r, .ext_en_r, .ext_we_r,
        .ext_sync_r, .ext_addr_r, .ext_wdata_r);
    target_model #(.CODE_PAT(CODE_PAT), .PERIPH_PAT(PERIPH_PAT), .PPB_PAT(PPB_PAT),
        .SYS_PAT(SYS_PAT)) u_targets (.ref_clk, .sram_en_r, .sram_we_r, .sram_addr_r,
        .sram_wdata_r, .ext_en_r, .ext_addr_r, .sram_rdata, .ext_rdata, .code_rdata,
        .periph_rdata, .ppb_rdata, .sys_rdata);

    initial begin
        ref_clk = 1'h0;
        forever #25 ref_clk = ~ref_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task check(input logic ok, input string msg);
        tests_run++;
        if (ok !== 1'h1) begin
            bad_count++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask : check

    task wrap_up;
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : wrap_up

    function automatic target_t exp_tgt(input logic [31:0] a, input logic f);
        target_t t;
        t = TGT_NONE;
        // the code-region sram block is served as code
        if (a <= FLASH_LAST || (a >= SRAM_LO_BASE && a <= CODE_LAST)) t = TGT_CODE;
        else if (a >= SRAM_HI_BASE && a <= SRAM_HI_LAST) t = TGT_SRAM;
        else if (a >= ALIAS_BASE && a <= 32'h220F_FFFF) t = TGT_SRAM;
        else if (a >= PERIPH_BASE && a <= PERIPH_LAST) t = TGT_PERIPH;
        else if (a >= EXT_BASE && a <= EXT_LAST) t = TGT_EXT;
        else if (a >= PPB_BASE && a <= PPB_LAST) t = TGT_PPB;
        else if (a >= 32'hA000_0000) t = TGT_SYS;
        if (f && t != TGT_CODE && t != TGT_SRAM && (t != TGT_EXT || !ext_width16)) t = TGT_NONE;
        return t;
    endfunction : exp_tgt

    function automatic int exp_lat(input logic [31:0] a, input logic w, input logic [1:0] sz,
                                   input target_t t);
        if (t == TGT_NONE) return 1;
        if (t == TGT_EXT) return EXT_ACCESS_CYCLES + 1;
        if (w && a >= ALIAS_BASE && a <= ALIAS_LAST) return 3;
        if ((sz == 2'h2 && a[1:0] != 2'h0) || (sz == 2'h1 && a[0])) return 2 + UNALIGNED_EXTRA;
        return 2;
    endfunction : exp_lat

    // request held from one falling edge; taken at the next rising edge
    task access(input logic w, input logic f, input logic [1:0] sz, input logic [31:0] a,
                input logic [31:0] d);
        @(negedge ref_clk);
        req_valid = 1'h1;
        req_write = w;
        req_fetch = f;
        req_size = sz;
        req_addr = a;
        req_wdata = d;
        @(negedge ref_clk);
        req_valid = 1'h0;
        xa = ext_addr_r;
        xw = ext_wdata_r;
        ext_cyc = int'(ext_en_r === 1'h1);
        lat = 1;
        while (lat < 12 && resp_valid !== 1'h1) begin
            @(negedge ref_clk);
            lat++;
            ext_cyc += int'(ext_en_r === 1'h1);
        end
        rd = resp_rdata;
        er = resp_error;
    endtask : access

    task route(input logic w, input logic f, input logic [1:0] sz, input logic [31:0] a,
               input logic [31:0] d);
        target_t t;
        t = exp_tgt(a, f);
        access(w, f, sz, a, d);
        check(er === (t == TGT_NONE), "error flag");
        check(lat == exp_lat(a, w, sz, t), "response latency");
        check(target_r === t, "target");
        if (t != TGT_NONE) begin
            check(bus_sel_r === exp_bus(a, f), "bus select");
            check(emi_ctrl_sel_r === (a >= EMI_CTRL_BASE && a <= EMI_CTRL_LAST), "ctrl");
            check(vector_fetch_r === (f && a == VECTOR_BASE), "vector fetch");
        end
        if (t == TGT_EXT) check(ext_cyc == EXT_ACCESS_CYCLES, "external cycles");
        if (t == TGT_EXT) check(ext_we_r === w, "ext write strobe");
        if (!w && t == TGT_CODE) check(rd === CODE_PAT, "code data");
        if (!w && t == TGT_PERIPH) check(rd === PERIPH_PAT, "peripheral data");
        if (!w && t == TGT_PPB) check(rd === PPB_PAT, "private data");
        if (!w && t == TGT_SYS) check(rd === SYS_PAT, "system data");
    endtask : route

    function automatic bus_sel_t exp_bus(input logic [31:0] a, input logic f);
        if (a <= CODE_LAST) return f ? BUS_INSTRUCTION_CODE_BUS : BUS_DATA_CODE_BUS;
        if (a >= PPB_BASE && a <= PPB_LAST) return BUS_PRIV;
        return BUS_SYSTEM;
    endfunction : exp_bus

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {req_valid, req_write, req_fetch, ext_sync_mode} = 4'h0;
        ext_width16 = 1'h1;
        req_size = 2'h2;
        req_addr = 32'h0;
        req_wdata = 32'h0;
        srst = 1'h1;
        repeat (2) @(negedge ref_clk);
        srst = 1'h0;
        foreach (corners[i]) route(1'h0, corners[i][32], 2'h2, corners[i][31:0], 32'h0);
        route(1'h0, 1'h0, 2'h2, 32'h2000_0001, 32'h0);
        route(1'h1, 1'h0, 2'h1, 32'h2000_0003, 32'h0);
        route(1'h0, 1'h0, 2'h1, 32'h2000_0006, 32'h0);
        for (int m = 0; m < 2; m++) begin
            ext_width16 = m[0];
            route(1'h0, 1'h1, 2'h1, EXT_BASE + 32'h2, 32'h0);
            wv = $random(seed);
            route(1'h1, 1'h0, 2'h1, EXT_LAST - 32'h1, wv);
            check(xa === 24'hFF_FFFE, "ext address");
            check(xw === (m ? wv[15:0] : {8'h00, wv[7:0]}), "ext write data");
            route(1'h0, 1'h0, 2'h1, EXT_BASE + 32'h0012_3456, 32'h0);
            check(rd === (m ? 32'h0000_6E6A : 32'h0000_006A), "ext read data");
        end
        @(negedge ref_clk);
        srst = 1'h1;
        @(negedge ref_clk);
        srst = 1'h0;
        check({resp_valid, sram_en_r, ext_en_r} === 3'h0 && target_r === TGT_NONE, "reset");
        repeat (6) begin
            @(negedge ref_clk);
            v = 1'($random(seed));
            ext_sync_mode = v;
            @(negedge ref_clk);
            check(ext_sync_r === v, "memory type strap");
        end
        repeat (8) begin
            k = $random(seed) & 7;
            b = $random(seed) & 31;
            wv = $random(seed);
            v = 1'($random(seed));
            route(1'h1, 1'h0, 2'h2, SRAM_HI_BASE + 32'(k * 4), wv);
            route(1'h1, 1'h0, 2'h2, ALIAS_BASE + 32'((k * 32 + b) * 4), {31'($random(seed)), v});
            wv[b] = v;
            route(1'h0, 1'h0, 2'h2, SRAM_HI_BASE + 32'(k * 4), 32'h0);
            check(rd === wv, "bit-band write");
            route(1'h0, 1'h0, 2'h2, ALIAS_BASE + 32'((k * 32 + b) * 4), 32'h0);
            check(rd === {31'h0, v}, "bit-band read");
        end
        repeat (60) begin
            b = $random(seed);
            k = {$random(seed)} % 9;
            ext_width16 = b[2];
            route(b[0], b[1] & !b[0], 2'h2, bases[k] + ($random(seed) & 32'h000F_FFFC),
                  $random(seed));
        end
        wrap_up();
    end

    initial begin
        #1_000_000;
        bad_count++;
        wrap_up();
    end
endmodule : system_address_decoder_tb
